// *** bench/dah_host_model.sv ***
module dah_host_model
(
	input wire logic pause,
	input wire logic go,
	input wire logic near,
	output logic hold_pin,
	output logic start_pin,
	output logic limit_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Contacts of the host controller
	// ------------------------------------------------------------
	// Normally closed wiring: a low contact asks for hold
	assign hold_pin = !pause;
	assign start_pin = go;
	assign limit_pin = near;
endmodule // dah_host_model

// *** bench/test_driver_io_autostart_homing.sv ***
module test_driver_io_autostart_homing
	import dah_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic CLK = 1'b0, RESET_N = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] prot = 3'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic servo_in = 1'b0, alarm = 1'b0, abs_home = 1'b0;
	logic pause = 1'b1, go = 1'b0, near = 1'b0;
	logic hold_pin, start_pin, limit_pin;
	logic normal, in_op, complete, defined, servo_on, step, seek;
	int failures = 0, comparisons = 0, cycles = 0, moves = 0;
	int seed = 34643;
	int m, v;
	logic [31:0] exp_ar;

	dah_top #(.INIT_CYCLES(80), .START_CYCLES(10), .DWELL_CYCLES(10)) i_dut (
		.CLK(CLK), .RESET_N(RESET_N),
		.S_AWADDR(awaddr), .S_AWPROT(prot), .S_AWVALID(awvalid),
		.S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(wstrb),
		.S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp),
		.S_BVALID(bvalid), .S_BREADY(bready), .S_ARADDR(araddr),
		.S_ARPROT(prot), .S_ARVALID(arvalid), .S_ARREADY(arready),
		.S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid),
		.S_RREADY(rready), .SERVO_ENABLE_INPUT(servo_in),
		.HOLD_INPUT(hold_pin), .HOME_START_INPUT(start_pin),
		.HOME_LIMIT_INPUT(limit_pin), .ALARM_INPUT(alarm),
		.ABS_HOME_VALID(abs_home), .NORMAL_STATE_OUTPUT(normal),
		.IN_OPERATION_OUTPUT(in_op), .HOME_COMPLETE_OUTPUT(complete),
		.HOME_DEFINED_OUTPUT(defined), .SERVO_ON_OUTPUT(servo_on),
		.INCREMENTAL_USER_MOVE(step), .HOME_SEEK_OUTPUT(seek));

	dah_host_model i_host (.pause(pause), .go(go), .near(near),
		.hold_pin(hold_pin), .start_pin(start_pin), .limit_pin(limit_pin));

	// ------------------------------------------------------------
	// Clock, move counter and hang guard
	// ------------------------------------------------------------
	initial
	begin
		forever #20 CLK = !CLK;
	end

	always @(posedge CLK)
	begin
		cycles <= cycles + 1;
		if (step === 1'b1)
			moves <= moves + 1;
		if (cycles == 20000)
		begin
			failures++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		comparisons++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask

	// Address and data are offered together; each drops when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge CLK);
		awaddr <= a;
		wdata <= d;
		prot <= 3'($random(seed));
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge CLK);
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge CLK);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge CLK);
			arvalid <= arvalid && !arready;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", ed, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	// Out-of-range channel writes leave the old value
	function automatic logic [31:0] next_ar(input logic [31:0] o,
		input int x);
		return (x >= -1 && x <= 255) ? 32'(x) : o;
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge CLK);
		RESET_N <= 1'b1;
		cyc(2);
		rd(REG_AUTORUN, 32'hFFFF_FFFF, RESP_OKAY);
		rd(REG_SCALE, 32'(SCALE_RST), RESP_OKAY);
		rd(REG_CTRL, 32'h0000_0003, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(8'h14, 32'h1, RESP_SLVERR);
		wr(REG_AUTORUN, 32'h0, RESP_OKAY);
		wr(REG_SCALE, 32'h4, RESP_OKAY);
		chk("normal_init", 1'b0, normal);
		while (normal !== 1'b1)
			@(posedge CLK);
		cyc(4);
		chk("in_op_hold", 1'b1, in_op);
		chk("servo_on", 1'b1, servo_on);
		chk("defined", 1'b0, defined);
		pause <= 1'b0;
		cyc(6);
		chk("moves_early", 0, moves);
		cyc(60);
		chk("moves_run", 1, moves >= 3 && moves <= 6);
		pause <= 1'b1;
		cyc(4);
		m = moves;
		cyc(40);
		chk("moves_held", m, moves);
		chk("in_op_held", 1'b1, in_op);
		rd(REG_POS, 32'(moves % 4), RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0007, RESP_OKAY);
		go <= 1'b1;
		cyc(3);
		chk("seek_start", 1'b1, seek);
		near <= 1'b1;
		cyc(3);
		chk("seek_end", 1'b0, seek);
		chk("defined", 1'b1, defined);
		chk("complete", 1'b1, complete);
		rd(REG_POS, 32'h0, RESP_OKAY);
		near <= 1'b0;
		cyc(5);
		chk("seek_once", 1'b0, seek);
		go <= 1'b0;
		wr(REG_CTRL, 32'h0000_000F, RESP_OKAY);
		cyc(2);
		chk("seek_cmd", 1'b1, seek);
		chk("complete_clr", 1'b0, complete);
		near <= 1'b1;
		cyc(3);
		chk("complete_cmd", 1'b1, complete);
		near <= 1'b0;
		m = moves;
		pause <= 1'b0;
		while (moves != m + 1)
			@(posedge CLK);
		pause <= 1'b1;
		cyc(3);
		rd(REG_POS, 32'h1, RESP_OKAY);
		chk("complete_off", 1'b0, complete);
		wr(REG_CTRL, 32'h0000_0017, RESP_OKAY);
		cyc(3);
		rd(REG_POS, 32'h0, RESP_OKAY);
		chk("complete_teach", 1'b1, complete);
		wstrb <= 4'h2;
		wr(REG_SCALE, 32'h0000_0105, RESP_OKAY);
		wstrb <= 4'hF;
		rd(REG_SCALE, 32'h0000_0104, RESP_OKAY);
		exp_ar = 32'h0;
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 256 : (i == 1) ? -1 : $random(seed) % 300;
			wr(REG_AUTORUN, 32'(v), RESP_OKAY);
			exp_ar = next_ar(exp_ar, v);
			rd(REG_AUTORUN, exp_ar, RESP_OKAY);
		end
		wr(REG_CTRL, 32'h0000_0002, RESP_OKAY);
		cyc(3);
		chk("servo_no", 1'b0, servo_on);
		servo_in <= 1'b1;
		cyc(3);
		chk("servo_no_on", 1'b1, servo_on);
		alarm <= 1'b1;
		cyc(4);
		chk("normal_alarm", 1'b0, normal);
		chk("in_op_alarm", 1'b0, in_op);
		alarm <= 1'b0;
		RESET_N <= 1'b0;
		abs_home <= 1'b1;
		cyc(6);
		RESET_N <= 1'b1;
		while (normal !== 1'b1)
			@(posedge CLK);
		cyc(3);
		chk("defined_kept", 1'b1, defined);
		chk("no_autorun", 1'b0, in_op);
		rd(REG_STATUS, 32'h0000_FF25, RESP_OKAY);
		end_of_test();
	end
endmodule // test_driver_io_autostart_homing

// *** rtl/dah_axil.sv ***
module dah_axil
	import dah_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	dah_regbus_if.bus rb
);
	logic aw_full_q, w_full_q, aw_full_d, w_full_d, bvalid_d, rvalid_d;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic fire;

	assign fire = aw_full_q & w_full_q & ~bvalid;
	assign aw_full_d = (awvalid & awready) | (aw_full_q & ~fire);
	assign w_full_d = (wvalid & wready) | (w_full_q & ~fire);
	assign bvalid_d = fire | (bvalid & ~bready);
	assign rvalid_d = (arvalid & arready) | (rvalid & ~rready);
	assign rb.wr_stb = fire;
	assign rb.wr_addr = awaddr_q;
	assign rb.wr_data = wdata_q;
	assign rb.wr_strb = wstrb_q;
	assign rb.rd_addr = araddr;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			if (awvalid && awready)
				awaddr_q <= awaddr;
			if (wvalid && wready)
			begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			awready <= ~aw_full_d & ~bvalid_d;
			wready <= ~w_full_d & ~bvalid_d;
			bvalid <= bvalid_d;
			if (fire)
				bresp <= dah_reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end
		else
		begin
			arready <= ~rvalid_d;
			rvalid <= rvalid_d;
			if (arvalid && arready)
			begin
				rdata <= dah_reg_known(araddr) ? rb.rd_data : 32'h00000000;
				rresp <= dah_reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
endmodule // dah_axil

// *** rtl/dah_pkg.sv ***
package dah_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int INIT_MS = 100;
	localparam int START_DELAY_MS = 3200;
	localparam int DWELL_MS = 1000;
	localparam int INIT_CYC = INIT_MS * CYC_PER_MS;
	localparam int START_DELAY_CYC = START_DELAY_MS * CYC_PER_MS;
	localparam int DWELL_CYC = DWELL_MS * CYC_PER_MS;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_AUTORUN = 8'h04;
	localparam logic [7:0] REG_SCALE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_POS = 8'h10;

	localparam int CTRL_SERVO_NC = 0;
	localparam int CTRL_HOLD_NC = 1;
	localparam int CTRL_HOME_IO = 2;
	localparam int CTRL_SEARCH = 3;
	localparam int CTRL_TEACH = 4;
	localparam logic [2:0] CTRL_RST = 3'h3;

	localparam logic [8:0] AUTORUN_RST = 9'h1FF;
	localparam logic [21:0] SCALE_RST = 22'h057E40;
	localparam logic [21:0] SCALE_MAX = 22'h280000;

	localparam int ST_NORMAL = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_HOLD = 2;
	localparam int ST_HOMING = 3;
	localparam int ST_HOME_CMP = 4;
	localparam int ST_HOME_DEF = 5;
	localparam int ST_SERVO = 6;
	localparam int ST_CHAN = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		P_INIT = 3'b000,
		P_IDLE = 3'b001,
		P_WAIT = 3'b010,
		P_DELAY = 3'b011,
		P_MOVE = 3'b100,
		P_DWELL = 3'b101
	} dah_prog_e;

	function automatic logic dah_reg_known(input logic [7:0] a);
		return (a == REG_CTRL) || (a == REG_AUTORUN) || (a == REG_SCALE) ||
			(a == REG_STATUS) || (a == REG_POS);
	endfunction

	function automatic logic [31:0] dah_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	function automatic logic [21:0] dah_next_pos(input logic [21:0] p,
		input logic [21:0] div);
		logic [22:0] n;
		n = {1'b0, p} + 23'h000001;
		return (n >= {1'b0, div}) ? 22'h000000 : n[21:0];
	endfunction

endpackage

// *** rtl/dah_regbus_if.sv ***
interface dah_regbus_if;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	modport bus (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
		input rd_data);
	modport core (input wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
		output rd_data);
endinterface

// *** rtl/dah_timer.sv ***
module dah_timer
	import dah_pkg::*;
#(
	parameter int W = 27,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic run,
	output logic done
);
	logic [W-1:0] count_q;

	// Hold freezes the count rather than clearing it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= RST_VAL;
		else if (load)
			count_q <= load_val;
		else if (run && count_q != '0)
			count_q <= count_q - 1'b1;
	end

	assign done = (count_q == '0);
endmodule // dah_timer

// *** rtl/dah_top.sv ***
module dah_top
	import dah_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYC,
	parameter int START_CYCLES = START_DELAY_CYC,
	parameter int DWELL_CYCLES = DWELL_CYC,
	parameter int TMR_W = 27
)
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] S_AWADDR,
	input wire logic [2:0] S_AWPROT,
	input wire logic S_AWVALID,
	output logic S_AWREADY,
	input wire logic [31:0] S_WDATA,
	input wire logic [3:0] S_WSTRB,
	input wire logic S_WVALID,
	output logic S_WREADY,
	output logic [1:0] S_BRESP,
	output logic S_BVALID,
	input wire logic S_BREADY,
	input wire logic [7:0] S_ARADDR,
	input wire logic [2:0] S_ARPROT,
	input wire logic S_ARVALID,
	output logic S_ARREADY,
	output logic [31:0] S_RDATA,
	output logic [1:0] S_RRESP,
	output logic S_RVALID,
	input wire logic S_RREADY,
	input wire logic SERVO_ENABLE_INPUT,
	input wire logic HOLD_INPUT,
	input wire logic HOME_START_INPUT,
	input wire logic HOME_LIMIT_INPUT,
	input wire logic ALARM_INPUT,
	input wire logic ABS_HOME_VALID,
	output logic NORMAL_STATE_OUTPUT,
	output logic IN_OPERATION_OUTPUT,
	output logic HOME_COMPLETE_OUTPUT,
	output logic HOME_DEFINED_OUTPUT,
	output logic SERVO_ON_OUTPUT,
	output logic INCREMENTAL_USER_MOVE,
	output logic HOME_SEEK_OUTPUT
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	generate
		if (TMR_W < 2 || TMR_W > 31)
			$error("dah_top: TMR_W out of range");
		if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << TMR_W))
			$error("dah_top: INIT_CYCLES does not fit timer");
		if (START_CYCLES < 2 || START_CYCLES >= (1 << TMR_W))
			$error("dah_top: START_CYCLES does not fit timer");
		if (DWELL_CYCLES < 2 || DWELL_CYCLES >= (1 << TMR_W))
			$error("dah_top: DWELL_CYCLES does not fit timer");
	endgenerate

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	dah_regbus_if rb ();

	dah_axil u_axil (
		.clk(CLK),
		.rst_n(RESET_N),
		.awaddr(S_AWADDR),
		.awvalid(S_AWVALID),
		.awready(S_AWREADY),
		.wdata(S_WDATA),
		.wstrb(S_WSTRB),
		.wvalid(S_WVALID),
		.wready(S_WREADY),
		.bresp(S_BRESP),
		.bvalid(S_BVALID),
		.bready(S_BREADY),
		.araddr(S_ARADDR),
		.arvalid(S_ARVALID),
		.arready(S_ARREADY),
		.rdata(S_RDATA),
		.rresp(S_RRESP),
		.rvalid(S_RVALID),
		.rready(S_RREADY),
		.rb(rb)
	);

	dah_prog_e state_q;
	logic [2:0] ctrl_q;
	logic [8:0] autorun_channel_param_q;
	logic [21:0] scale_division_param_q;
	logic [21:0] pos_q;
	logic hold_q, homing_q, home_done_q, home_defined_q, start_prev_q;
	logic wr_ctrl, wr_auto, wr_scale;
	logic [31:0] ctrl_wv, auto_wv, scale_wv;
	logic search_cmd, teach_cmd, start_rise, home_go, limit_hit;
	logic step_now, prog_go, running, tmr_done, tmr_load;
	logic [TMR_W-1:0] tmr_val;

	assign wr_ctrl = rb.wr_stb && rb.wr_addr == REG_CTRL;
	assign wr_auto = rb.wr_stb && rb.wr_addr == REG_AUTORUN;
	assign wr_scale = rb.wr_stb && rb.wr_addr == REG_SCALE;
	assign ctrl_wv = dah_merge({29'h0, ctrl_q}, rb.wr_data, rb.wr_strb);
	assign auto_wv = dah_merge({{23{autorun_channel_param_q[8]}},
		autorun_channel_param_q}, rb.wr_data, rb.wr_strb);
	assign scale_wv = dah_merge({10'h000, scale_division_param_q},
		rb.wr_data, rb.wr_strb);

	// Command bits are self-clearing and read back as zero
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			ctrl_q <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= ctrl_wv[2:0];
	end

	// Out-of-range values are dropped, keeping the old setting
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			autorun_channel_param_q <= AUTORUN_RST;
		else if (wr_auto && (auto_wv == 32'hFFFFFFFF ||
			auto_wv <= 32'h000000FF))
			autorun_channel_param_q <= auto_wv[8:0];
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			scale_division_param_q <= SCALE_RST;
		else if (wr_scale && scale_wv != 32'h0 &&
			scale_wv <= {10'h000, SCALE_MAX})
			scale_division_param_q <= scale_wv[21:0];
	end

	always_comb
	begin
		rb.rd_data = 32'h00000000;
		case (rb.rd_addr)
			REG_CTRL: rb.rd_data = {29'h0, ctrl_q};
			REG_AUTORUN: rb.rd_data = {{23{autorun_channel_param_q[8]}},
				autorun_channel_param_q};
			REG_SCALE: rb.rd_data = {10'h000, scale_division_param_q};
			REG_STATUS:
			begin
				rb.rd_data[ST_NORMAL] = NORMAL_STATE_OUTPUT;
				rb.rd_data[ST_BUSY] = IN_OPERATION_OUTPUT;
				rb.rd_data[ST_HOLD] = hold_q;
				rb.rd_data[ST_HOMING] = homing_q;
				rb.rd_data[ST_HOME_CMP] = HOME_COMPLETE_OUTPUT;
				rb.rd_data[ST_HOME_DEF] = HOME_DEFINED_OUTPUT;
				rb.rd_data[ST_SERVO] = SERVO_ON_OUTPUT;
				rb.rd_data[ST_CHAN +: 8] = autorun_channel_param_q[7:0];
			end
			REG_POS: rb.rd_data = {10'h000, pos_q};
			default: rb.rd_data = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// Contact inputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			SERVO_ON_OUTPUT <= 1'b0;
			hold_q <= 1'b1;
		end
		else
		begin
			SERVO_ON_OUTPUT <= SERVO_ENABLE_INPUT ^ ctrl_q[CTRL_SERVO_NC];
			hold_q <= HOLD_INPUT ^ ctrl_q[CTRL_HOLD_NC];
		end
	end

	// ----------------------------------------------------------------
	// Stored program sequencer
	// ----------------------------------------------------------------
	dah_timer #(
		.W(TMR_W),
		.RST_VAL(TMR_W'(INIT_CYCLES))
	) u_timer (
		.clk(CLK),
		.rst_n(RESET_N),
		.load(tmr_load),
		.load_val(tmr_val),
		.run(state_q == P_INIT || !hold_q),
		.done(tmr_done)
	);

	assign running = state_q == P_WAIT || state_q == P_DELAY ||
		state_q == P_MOVE || state_q == P_DWELL;
	assign prog_go = SERVO_ON_OUTPUT && !hold_q;
	// Program steps wait while a home return owns the motor
	assign step_now = state_q == P_MOVE && !hold_q && !homing_q;
	assign tmr_load = (state_q == P_WAIT && prog_go) || step_now;
	assign tmr_val = step_now ? TMR_W'(DWELL_CYCLES) : TMR_W'(START_CYCLES);

	// An alarm ends the program; only a reboot restarts it
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			state_q <= P_INIT;
		else if (running && ALARM_INPUT)
			state_q <= P_IDLE;
		else
		begin
			case (state_q)
				P_INIT:
					if (tmr_done)
						state_q <= autorun_channel_param_q[8] ? P_IDLE : P_WAIT;
				P_IDLE: state_q <= P_IDLE;
				P_WAIT:
					if (prog_go)
						state_q <= P_DELAY;
				P_DELAY:
					if (tmr_done)
						state_q <= P_MOVE;
				P_MOVE:
					if (step_now)
						state_q <= P_DWELL;
				P_DWELL:
					if (tmr_done)
						state_q <= P_MOVE;
				default: state_q <= P_INIT;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			NORMAL_STATE_OUTPUT <= 1'b0;
			IN_OPERATION_OUTPUT <= 1'b0;
			INCREMENTAL_USER_MOVE <= 1'b0;
		end
		else
		begin
			NORMAL_STATE_OUTPUT <= state_q != P_INIT && !ALARM_INPUT;
			IN_OPERATION_OUTPUT <= running;
			INCREMENTAL_USER_MOVE <= step_now;
		end
	end

	// ----------------------------------------------------------------
	// Home return
	// ----------------------------------------------------------------
	assign search_cmd = wr_ctrl && ctrl_wv[CTRL_SEARCH];
	assign teach_cmd = wr_ctrl && ctrl_wv[CTRL_TEACH] && !homing_q;
	assign start_rise = HOME_START_INPUT && !start_prev_q &&
		ctrl_q[CTRL_HOME_IO];
	assign home_go = (start_rise || search_cmd) && !homing_q &&
		SERVO_ON_OUTPUT && NORMAL_STATE_OUTPUT;
	assign limit_hit = homing_q && HOME_LIMIT_INPUT &&
		ctrl_q[CTRL_HOME_IO];

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			start_prev_q <= 1'b0;
		else
			start_prev_q <= HOME_START_INPUT;
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			homing_q <= 1'b0;
		else if (limit_hit || ALARM_INPUT)
			homing_q <= 1'b0;
		else if (home_go)
			homing_q <= 1'b1;
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			home_done_q <= 1'b0;
		else if (limit_hit || teach_cmd)
			home_done_q <= 1'b1;
		else if (home_go)
			home_done_q <= 1'b0;
	end

	// Retained home is picked up as initialisation ends
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			home_defined_q <= 1'b0;
		else if (limit_hit || teach_cmd)
			home_defined_q <= 1'b1;
		else if (state_q == P_INIT && tmr_done && ABS_HOME_VALID)
			home_defined_q <= 1'b1;
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			pos_q <= 22'h000000;
		else if (limit_hit)
			pos_q <= 22'h000000;
		else if (teach_cmd)
			pos_q <= 22'h000000;
		else if (step_now)
			pos_q <= dah_next_pos(pos_q, scale_division_param_q);
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			HOME_COMPLETE_OUTPUT <= 1'b0;
			HOME_DEFINED_OUTPUT <= 1'b0;
			HOME_SEEK_OUTPUT <= 1'b0;
		end
		else
		begin
			HOME_COMPLETE_OUTPUT <= home_done_q && pos_q == 22'h0;
			HOME_DEFINED_OUTPUT <= home_defined_q;
			HOME_SEEK_OUTPUT <= homing_q || home_go;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_released;
		(state_q == P_WAIT && prog_go && !ALARM_INPUT) ##1
		(state_q == P_DELAY && !ALARM_INPUT);
	endsequence

	sequence s_homed;
		limit_hit ##1 (pos_q == 22'h0 && home_defined_q);
	endsequence

	a_servo_polarity: assert property (@(posedge CLK) disable iff (!RESET_N)
		(ctrl_q[CTRL_SERVO_NC] && !SERVO_ENABLE_INPUT && !wr_ctrl) |=>
		SERVO_ON_OUTPUT)
		else $error("servo not on with unwired closed input");
	a_step_wrap: assert property (@(posedge CLK) disable iff (!RESET_N)
		(step_now && !limit_hit && !teach_cmd) |=> (pos_q == dah_next_pos(
		$past(pos_q), $past(scale_division_param_q)) && INCREMENTAL_USER_MOVE))
		else $error("step did not advance by one division");
	a_autorun_start: assert property (@(posedge CLK) disable iff (!RESET_N)
		(state_q == P_INIT && tmr_done && !autorun_channel_param_q[8]) |=>
		state_q == P_WAIT ##1 IN_OPERATION_OUTPUT)
		else $error("autorun did not start");
	a_autorun_off: assert property (@(posedge CLK) disable iff (!RESET_N)
		(state_q == P_INIT && autorun_channel_param_q[8]) |=>
		!IN_OPERATION_OUTPUT)
		else $error("disabled autorun ran");
	a_init_normal: assert property (@(posedge CLK) disable iff (!RESET_N)
		(state_q == P_INIT) |=> !NORMAL_STATE_OUTPUT)
		else $error("normal output closed during init");
	a_hold_busy: assert property (@(posedge CLK) disable iff (!RESET_N)
		(hold_q && running && !ALARM_INPUT) |-> (!step_now ##1
		(IN_OPERATION_OUTPUT && !INCREMENTAL_USER_MOVE)))
		else $error("hold did not suspend with busy closed");
	a_start_delay: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_released |-> (state_q == P_DELAY && !step_now)[*2])
		else $error("move issued before start delay");
	a_dwell_gap: assert property (@(posedge CLK) disable iff (!RESET_N)
		step_now |=> (!step_now)[*2])
		else $error("steps closer than dwell");
	a_limit_origin: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_homed |-> (!homing_q ##1 HOME_DEFINED_OUTPUT && HOME_COMPLETE_OUTPUT))
		else $error("home limit did not define origin");
	a_teach_home: assert property (@(posedge CLK) disable iff (!RESET_N)
		teach_cmd |=> (pos_q == 22'h0 && home_defined_q && home_done_q))
		else $error("teach did not set home");
	a_start_edge: assert property (@(posedge CLK) disable iff (!RESET_N)
		(HOME_START_INPUT && start_prev_q && !search_cmd && !homing_q) |=>
		!homing_q)
		else $error("level on start input relaunched homing");
	a_search_cmd: assert property (@(posedge CLK) disable iff (!RESET_N)
		(search_cmd && !homing_q && SERVO_ON_OUTPUT && NORMAL_STATE_OUTPUT &&
		!ALARM_INPUT) |=> (homing_q && HOME_SEEK_OUTPUT))
		else $error("search command did not start homing");
	a_home_cmp: assert property (@(posedge CLK) disable iff (!RESET_N)
		HOME_COMPLETE_OUTPUT |-> $past(home_done_q && pos_q == 22'h0))
		else $error("home complete closed away from home");
	a_alarm_open: assert property (@(posedge CLK) disable iff (!RESET_N)
		ALARM_INPUT |=> !NORMAL_STATE_OUTPUT)
		else $error("normal output closed during alarm");
endmodule // dah_top
